// *** pei_event_irq.sv ***
// event interrupt enables, sticky event flags and deep sleep control
// assumes register accesses arrive as one-cycle strobes from the serial engine
// Behaviour
// - enable bits 7..4 for jabber, rx error, page, parallel fault; reset 0.
// - enable bits 3..0 for partner ack, link down, remote fault, link up.
// - status bit 10 flags wake from deep sleep; write 1 clears, resets 0.
// - status bit 9 flags entry into deep sleep; write 1 clears, resets 0.
// - status bit 8 flags auto-negotiation complete; resets 0.
// - status bits 7..4 flag jabber, rx error, page, parallel fault.
// - status bits 3..0 flag partner ack, link down, remote fault, link up.
// - status bits 15..11 always read zero.
// - fifo half-full field bits 15..12, read-write, resets to 2.
// - deep sleep allowed only when power control bit 8 is set.
// - bit 7 lets the pll power down while in deep sleep.
// - bit 6 lets the fast receiver power down in deep sleep.
// - bit 5 lets the transmit converter power down in deep sleep.
// - bit 4 lets clock recovery power down in deep sleep.
// - interrupt pin active high when polarity bit set, else active low.
// - with read-clear set, a status read clears returned flags.
// - with auto-clear set, a flag clears once its condition goes away.
// - with re-setup set, writing 1 keeps a flag whose condition persists.
`timescale 1ns/100ps
module pei_event_irq
  (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register access from the management frame engine
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // event condition levels from the core
    input wire logic [8:0] event_cond,
    input wire logic sleep_request,
    // interrupt pin
    output logic irq_pin,
    // power and fifo controls
    output logic deep_sleep_state,
    output logic pll_sleep,
    output logic fast_receiver_sleep,
    output logic transmit_converter_sleep,
    output logic clock_recovery_sleep,
    output logic [3:0] fifo_half_level
  );
  import pei_pkg::*;

  logic [15:0] enable_reg;
  logic [10:0] flag_reg;
  logic [10:0] flag_next;
  logic [10:0] cond_reg;
  logic [3:0] fifo_reg;
  logic [11:0] pwr_reg;
  logic sleep_reg;
  logic [15:0] rdata_reg;
  logic irq_reg;
  logic [10:0] cond_all;
  logic [10:0] rise;
  logic [10:0] clr_mask;
  logic irq_active;
  logic wr_en;
  logic wr_st;
  logic wr_pw;
  logic rd_st;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // write strobes, one per register, plus a read strobe for the status register
  assign wr_en = reg_wr && (reg_addr == PEI_REG_EVENT_ENABLE);
  assign wr_st = reg_wr && (reg_addr == PEI_REG_EVENT_STATUS);
  assign wr_pw = reg_wr && (reg_addr == PEI_REG_FIFO_POWER);
  assign rd_st = reg_rd && (reg_addr == PEI_REG_EVENT_STATUS);

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // enable and interrupt control word
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      enable_reg <= PEI_EN_RESET;
    else if (wr_en)
      enable_reg <= reg_wdata;
  end

  // fifo level and power-down allows; low reserved bits are not stored
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      fifo_reg <= PEI_FIFO_RESET;
      pwr_reg <= PEI_PWR_RESET;
    end
    else if (wr_pw)
    begin
      fifo_reg <= reg_wdata[PEI_FIFO_MSB:PEI_FIFO_LSB];
      pwr_reg <= {reg_wdata[11:4], 4'h0};
    end
  end
  // fifo holds (n+3)*2 bits before it counts as half full
  assign fifo_half_level = fifo_reg;

  // ----------------------------------------
  // deep sleep
  // ----------------------------------------
  // sleep only while enabled; dropping the enable wakes on the next clock edge
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      sleep_reg <= 1'b0;
    else
      sleep_reg <= sleep_request && pwr_reg[PEI_SLEEP_EN_BIT];
  end
  assign deep_sleep_state = sleep_reg;
  // pwr_reg mirrors register bits 11:0 in place, so reads need no shuffle
  assign pll_sleep = sleep_reg && pwr_reg[PEI_PLL_ALLOW_BIT];
  assign fast_receiver_sleep = sleep_reg && pwr_reg[PEI_RX_ALLOW_BIT];
  assign transmit_converter_sleep = sleep_reg && pwr_reg[PEI_TX_ALLOW_BIT];
  assign clock_recovery_sleep = sleep_reg && pwr_reg[PEI_CDR_ALLOW_BIT];

  // ----------------------------------------
  // event flags
  // ----------------------------------------
  // wake condition is the inverse of sleep so its rising edge marks wake-up
  assign cond_all = {~sleep_reg, sleep_reg, event_cond};
  assign rise = cond_all & ~cond_reg;

  // previous condition levels for edge detection
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cond_reg <= PEI_COND_RESET;
    else
      cond_reg <= cond_all;
  end

  // clear sources: read, write of ones, vanished condition
  always_comb
  begin
    clr_mask = '0;
    if (rd_st && enable_reg[PEI_EN_READ_CLR_BIT])
      clr_mask = clr_mask | flag_reg;
    if (wr_st)
    begin
      if (enable_reg[PEI_EN_RESETUP_BIT])
        clr_mask = clr_mask | (reg_wdata[10:0] & ~cond_all);
      else
        clr_mask = clr_mask | reg_wdata[10:0];
    end
    if (enable_reg[PEI_EN_AUTO_CLR_BIT])
      clr_mask = clr_mask | ~cond_all;
  end

  // a new event wins over any clear in the same cycle
  assign flag_next = (flag_reg & ~clr_mask) | rise;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      flag_reg <= PEI_FLAG_RESET;
    else
      flag_reg <= flag_next;
  end

  // ----------------------------------------
  // interrupt pin
  // ----------------------------------------
  assign irq_active = enable_reg[PEI_EN_OUT_BIT]
    && |(flag_reg & enable_reg[10:0]);

  // registered pin so polarity changes never glitch it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      irq_reg <= PEI_PIN_RESET;
    else
      irq_reg <= enable_reg[PEI_EN_POLARITY_BIT] ? irq_active : ~irq_active;
  end
  assign irq_pin = irq_reg;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // captured on the read strobe; other addresses read zero
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rdata_reg <= '0;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        PEI_REG_EVENT_ENABLE: rdata_reg <= enable_reg;
        PEI_REG_EVENT_STATUS: rdata_reg <= {5'h00, flag_reg};
        PEI_REG_FIFO_POWER: rdata_reg <= {fifo_reg, pwr_reg};
        default: rdata_reg <= '0;
      endcase
    end
  end
  assign reg_rdata = rdata_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_ENABLE_STORE: assert property (wr_en |=> enable_reg[10:0] == $past(reg_wdata[10:0]))
    else $error("enable bits not stored");
  AST_FLAG_SET: assert property (|rise |=> ((flag_reg & $past(rise)) == $past(rise)))
    else $error("event did not set its flag");
  AST_RESERVED_ZERO: assert property (rd_st |=> reg_rdata[15:11] == 5'h00)
    else $error("reserved status bits not zero");
  AST_READ_CLEAR: assert property (rd_st && enable_reg[PEI_EN_READ_CLR_BIT] && !(|rise)
    |=> flag_reg == 11'h000)
    else $error("read did not clear flags");
  AST_READ_KEEP: assert property (!enable_reg[PEI_EN_READ_CLR_BIT]
    && !enable_reg[PEI_EN_AUTO_CLR_BIT] && !wr_st
    |=> (flag_reg & $past(flag_reg)) == $past(flag_reg))
    else $error("flag lost without a clear");
  AST_AUTO_CLEAR: assert property (enable_reg[PEI_EN_AUTO_CLR_BIT]
    |=> (flag_reg & ~$past(cond_all)) == 11'h000)
    else $error("flag kept after condition left");
  AST_WRITE_CLEAR: assert property (wr_st && !enable_reg[PEI_EN_RESETUP_BIT]
    |=> (flag_reg & $past(reg_wdata[10:0]) & ~$past(rise)) == 11'h000)
    else $error("write of one did not clear flag");
  AST_RESETUP_HOLD: assert property (wr_st && enable_reg[PEI_EN_RESETUP_BIT]
    |=> (flag_reg & $past(flag_reg & cond_all)) == $past(flag_reg & cond_all))
    else $error("flag with live condition was cleared");
  AST_PIN_LEVEL: assert property (##1 irq_pin
    == ($past(enable_reg[PEI_EN_POLARITY_BIT]) ? $past(irq_active) : !$past(irq_active)))
    else $error("interrupt pin level wrong");
  AST_SLEEP_GATE: assert property (!pwr_reg[PEI_SLEEP_EN_BIT] |=> !deep_sleep_state)
    else $error("deep sleep while disabled");
  AST_PLL_SLEEP: assert property (pll_sleep |-> deep_sleep_state
    && pwr_reg[PEI_PLL_ALLOW_BIT])
    else $error("pll asleep without permission");

  COV_IRQ_RAISED: cover property (irq_active ##1 irq_pin == enable_reg[PEI_EN_POLARITY_BIT]);
  COV_SLEEP_WAKE: cover property (deep_sleep_state ##[1:20] !deep_sleep_state);
  COV_READ_CLEAR: cover property (rd_st && enable_reg[PEI_EN_READ_CLR_BIT] && |flag_reg);
  COV_EVENT_ON_CLEAR: cover property (|(rise & clr_mask));
endmodule

// *** pei_event_irq_bench.sv ***
// self-checking bench for the event interrupt and deep sleep registers
// assumes the station model drives the register port on falling edges
`timescale 1ns/100ps
module pei_event_irq_bench;
  import pei_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [4:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [8:0] event_cond = 9'h000;
  logic sleep_request = 1'b0;
  logic irq_pin;
  logic [4:0] slp;
  logic [3:0] fifo_half_level;
  int fails = 0;
  int n_checks = 0;
  pei_sta_model sta (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  pei_event_irq uut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .event_cond(event_cond),
    .sleep_request(sleep_request), .irq_pin(irq_pin), .deep_sleep_state(slp[4]),
    .pll_sleep(slp[3]), .fast_receiver_sleep(slp[2]), .transmit_converter_sleep(slp[1]),
    .clock_recovery_sleep(slp[0]), .fifo_half_level(fifo_half_level));
  // -------------------------
  // compare helpers
  // -------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    sta.rd(a, d);
    chk($sformatf("reg %h", a), exp, d);
  endtask
  // let an event or sleep change reach flags and the registered pin
  task automatic settle;
    repeat (3) @(negedge clock);
  endtask
  // -------------------------
  // scenarios
  // -------------------------
  task automatic t_reset;
    rdchk(PEI_REG_EVENT_ENABLE, 16'h0000);
    rdchk(PEI_REG_EVENT_STATUS, 16'h0000);
    rdchk(PEI_REG_FIFO_POWER, 16'h2000);
    rdchk(5'h19, 16'h0000);
    chk("irq_pin", 16'h0001, {15'h0, irq_pin});
    $display("test reset done");
  endtask
  task automatic t_regs;
    sta.wr(PEI_REG_EVENT_ENABLE, 16'h5a5a);
    sta.wr(5'h19, 16'hffff);
    rdchk(PEI_REG_EVENT_ENABLE, 16'h5a5a);
    sta.wr(PEI_REG_FIFO_POWER, 16'hfff5);
    rdchk(PEI_REG_FIFO_POWER, 16'hfff0);
    chk("fifo", 16'h000f, {12'h0, fifo_half_level});
    chk("sleep", 16'h0000, {11'h0, slp});
    $display("test regs done");
  endtask
  task automatic t_events;
    sta.wr(PEI_REG_EVENT_ENABLE, 16'h81ff);
    for (int i = 0; i < 9; i++)
    begin
      event_cond = 9'(1 << i);
      settle;
      chk("irq_pin", 16'h0000, {15'h0, irq_pin});
      rdchk(PEI_REG_EVENT_STATUS, 16'(1 << i));
      event_cond = 9'h000;
      sta.wr(PEI_REG_EVENT_STATUS, 16'(1 << i));
      rdchk(PEI_REG_EVENT_STATUS, 16'h0000);
      chk("irq_pin", 16'h0001, {15'h0, irq_pin});
    end
    // a flag whose enable is off must not reach the pin
    sta.wr(PEI_REG_EVENT_ENABLE, 16'h8000);
    event_cond = 9'h001;
    settle;
    chk("irq_pin", 16'h0001, {15'h0, irq_pin});
    event_cond = 9'h000;
    sta.wr(PEI_REG_EVENT_STATUS, 16'h0001);
    $display("test events done");
  endtask
  task automatic t_sleep;
    sta.wr(PEI_REG_FIFO_POWER, 16'h21f0);
    sleep_request = 1'b1;
    settle;
    chk("sleep", 16'h001f, {11'h0, slp});
    rdchk(PEI_REG_EVENT_STATUS, 16'h0200);
    sleep_request = 1'b0;
    settle;
    chk("sleep", 16'h0000, {11'h0, slp});
    rdchk(PEI_REG_EVENT_STATUS, 16'h0600);
    sta.wr(PEI_REG_FIFO_POWER, 16'h2150);
    sleep_request = 1'b1;
    settle;
    chk("sleep", 16'h0015, {11'h0, slp});
    sta.wr(PEI_REG_FIFO_POWER, 16'h2000);
    settle;
    chk("sleep", 16'h0000, {11'h0, slp});
    sleep_request = 1'b0;
    sta.wr(PEI_REG_EVENT_STATUS, 16'h0600);
    rdchk(PEI_REG_EVENT_STATUS, 16'h0000);
    $display("test sleep done");
  endtask
  task automatic t_modes;
    sta.wr(PEI_REG_EVENT_ENABLE, 16'he001);
    event_cond = 9'h001;
    settle;
    chk("irq_pin", 16'h0001, {15'h0, irq_pin});
    rdchk(PEI_REG_EVENT_STATUS, 16'h0001);
    rdchk(PEI_REG_EVENT_STATUS, 16'h0000);
    event_cond = 9'h000;
    sta.wr(PEI_REG_EVENT_ENABLE, 16'h9001);
    event_cond = 9'h001;
    settle;
    rdchk(PEI_REG_EVENT_STATUS, 16'h0001);
    event_cond = 9'h000;
    settle;
    rdchk(PEI_REG_EVENT_STATUS, 16'h0000);
    sta.wr(PEI_REG_EVENT_ENABLE, 16'h8801);
    event_cond = 9'h001;
    settle;
    sta.wr(PEI_REG_EVENT_STATUS, 16'h0001);
    rdchk(PEI_REG_EVENT_STATUS, 16'h0001);
    event_cond = 9'h000;
    sta.wr(PEI_REG_EVENT_STATUS, 16'h0001);
    rdchk(PEI_REG_EVENT_STATUS, 16'h0000);
    $display("test modes done");
  endtask
  // -------------------------
  // run control
  // -------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always #50 clock = ~clock;
  // main sequence after a 16-cycle reset
  initial
  begin
    repeat (16) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_reset;
    t_regs;
    t_events;
    t_sleep;
    t_modes;
    test_done;
  end
  // hang guard: a run this long means something stalled
  initial
  begin
    repeat (5000) @(posedge clock);
    fails++;
    test_done;
  end
endmodule

// *** pei_pkg.sv ***
// constants for the event interrupt and deep sleep register block
// assumes the management frame engine presents decoded register accesses
package pei_pkg;
  // ----------------------------------------
  // register numbers on the management bus
  // ----------------------------------------
  localparam logic [4:0] PEI_REG_EVENT_ENABLE = 5'h16;
  localparam logic [4:0] PEI_REG_EVENT_STATUS = 5'h17;
  localparam logic [4:0] PEI_REG_FIFO_POWER = 5'h18;
  // ----------------------------------------
  // enable register fields
  // ----------------------------------------
  localparam int PEI_EN_OUT_BIT = 15;
  localparam int PEI_EN_READ_CLR_BIT = 14;
  localparam int PEI_EN_POLARITY_BIT = 13;
  localparam int PEI_EN_AUTO_CLR_BIT = 12;
  localparam int PEI_EN_RESETUP_BIT = 11;
  localparam int PEI_EVENT_COUNT = 11;
  localparam logic [15:0] PEI_EN_RESET = 16'h0000;
  // ----------------------------------------
  // status register fields
  // ----------------------------------------
  localparam int PEI_ST_WAKE_BIT = 10;
  localparam int PEI_ST_SLEEP_BIT = 9;
  localparam int PEI_CORE_EVENTS = 9;
  localparam logic [10:0] PEI_FLAG_RESET = 11'h000;
  // wake condition is "not asleep", which is true out of reset
  localparam logic [10:0] PEI_COND_RESET = 11'h400;
  // ----------------------------------------
  // fifo and power control fields
  // ----------------------------------------
  localparam int PEI_FIFO_MSB = 15;
  localparam int PEI_FIFO_LSB = 12;
  localparam logic [3:0] PEI_FIFO_RESET = 4'h2;
  localparam int PEI_SLEEP_EN_BIT = 8;
  localparam int PEI_PLL_ALLOW_BIT = 7;
  localparam int PEI_RX_ALLOW_BIT = 6;
  localparam int PEI_TX_ALLOW_BIT = 5;
  localparam int PEI_CDR_ALLOW_BIT = 4;
  localparam logic [11:0] PEI_PWR_RESET = 12'h000;
  // interrupt pin level at reset: polarity 0 means idle high
  localparam logic PEI_PIN_RESET = 1'b1;
endpackage

// *** pei_sta_model.sv ***
// management station model: issues single register accesses as strobes
// assumes the bench calls its tasks and that inputs move on falling edges
`timescale 1ns/100ps
module pei_sta_model
  (
    // clock
    input wire logic clock,
    // register port toward the block
    output logic [4:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata
  );
  // idle at time zero so no access is seen during reset
  initial
  begin
    reg_addr = 5'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // write strobe held across exactly one rising edge
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_wdata = ~d; // released data must not look valid
  endtask
  // read data is taken once the answering edge has passed
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
